// ---- pkg/mrss_pkg.sv ----
/*
 * Constants for the reset source sequencer: timing figures, cycle counts,
 * register offsets and reset values.
 * Assumes a 50 MHz system clock and an APB master with 32-bit data.
 */
// Function
// - A power-on reset clears the program counter so execution starts at address zero.
// - A power-on reset sets every port data and direction register to all ones.
// - The external reset pin held low resets the device, which restarts at zero after release.
// - While the reset pin is low, instruction execution is suppressed.
// - After reset release a start-up timer delay elapses before normal operation.
// - Low-voltage reset acts only when enabled, with a selectable trip threshold.
// - Only a low-supply indication lasting beyond the minimum duration causes a reset.
// - A qualified low-voltage reset has the same effect as a reset-pin reset.
// - A watchdog time-out in normal operation resets like the pin and sets the time-out flag.
// - A watchdog time-out in power-down clears only program counter and stack pointer.
// - Watchdog wake from power-down sets both flags; power-on clears both flags.
// - Every reset except a power-down watchdog wake stops the timer and clears its prescaler.
package mrss_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ              = 50_000_000;
    localparam int RESET_RELEASE_DELAY_US   = 100;
    localparam int LOW_SUPPLY_MIN_DURATION_US = 120;
    localparam int RELEASE_CYCLES =
        (RESET_RELEASE_DELAY_US * (CLK_FREQ_HZ / 1_000_000));
    localparam int LOW_SUPPLY_CYCLES =
        (LOW_SUPPLY_MIN_DURATION_US * (CLK_FREQ_HZ / 1_000_000));
    localparam int CNT_W                    = 16;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_EVENT   = 8'h08;
    localparam logic [7:0] OFS_CLEAR   = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h10;

    // ------------------------------------------------------------------
    // Reset values and field layouts
    // ------------------------------------------------------------------
    localparam logic [7:0] PORT_RESET_VAL = 8'hff;
    localparam logic [2:0] LVT_RESET_VAL  = 3'h0;
    localparam int         EV_W           = 4;
    localparam int         EV_POR         = 0;
    localparam int         EV_PIN         = 1;
    localparam int         EV_LVR         = 2;
    localparam int         EV_WDT         = 3;

    typedef enum logic [1:0] {
        MRSS_HOLD  = 2'b00,
        MRSS_DELAY = 2'b01,
        MRSS_RUN   = 2'b11
    } mrss_state_t;

endpackage

// ---- logic/mrss_qual.sv ----
/*
 * Qualifier that passes a level only after it has persisted for LIMIT cycles.
 * Assumes the input is synchronous to the clock.
 */
module mrss_qual #(
    parameter int LIMIT = 6000,
    parameter int W     = 16
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic level_in,
    output logic      qualified
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         at_limit;

    assign at_limit = (cnt_reg >= W'(LIMIT));
    assign cnt_next = !level_in ? '0 : (at_limit ? cnt_reg : cnt_reg + W'(1));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= '0;
            qualified <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            qualified <= level_in && at_limit;
        end
    end
endmodule

// ---- logic/mrss_top.sv ----
/*
 * Reset source sequencer: merges power-on, reset pin, low-voltage and
 * watchdog sources into one core reset, with start-up delay and flags.
 * Assumes synchronous inputs on sys_clk and an APB master for registers.
 */
// Design decisions made here: the APB slave port and the address map.
module mrss_top #(
    parameter int RELEASE_CYCLES = mrss_pkg::RELEASE_CYCLES,
    parameter int LOW_CYCLES     = mrss_pkg::LOW_SUPPLY_CYCLES
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 reset_pin_b,
    input  wire logic                 low_supply,
    input  wire logic                 lvr_option_en,
    input  wire logic                 watchdog_timeout,
    input  wire logic                 powerdown,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic                      core_run,
    output logic                      pc_clear,
    output logic                      sp_clear,
    output logic                      port_reset,
    output logic [7:0]                port_data_init,
    output logic [7:0]                port_dir_init,
    output logic                      timer_stop,
    output logic                      watchdog_timeout_flag,
    output logic                      powerdown_flag,
    output logic [2:0]                low_voltage_threshold,
    output logic                      irq
);
    import mrss_pkg::*;

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Source qualification
    // ------------------------------------------------------------------
    logic        lvr_level;
    logic        lvr_qual;
    logic        por_pend_reg;
    logic        wdt_normal;
    logic        wdt_pd;
    logic        any_full;
    logic        ctrl_lvr_en_reg;

    assign lvr_level  = low_supply && lvr_option_en && ctrl_lvr_en_reg;

    mrss_qual #(
        .LIMIT (LOW_CYCLES),
        .W     (CNT_W)
    ) u_lvr_qual (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .level_in  (lvr_level),
        .qualified (lvr_qual)
    );

    assign wdt_normal = watchdog_timeout && !powerdown;
    assign wdt_pd     = watchdog_timeout && powerdown;
    assign any_full   = por_pend_reg || !reset_pin_b || lvr_qual || wdt_normal;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    mrss_state_t      state_reg;
    mrss_state_t      state_next;
    logic [CNT_W-1:0] dly_reg;
    logic [CNT_W-1:0] dly_next;
    logic             dly_done;

    assign dly_done = (dly_reg >= CNT_W'(RELEASE_CYCLES - 1));

    always_comb begin
        state_next = state_reg;
        dly_next   = '0;
        case (state_reg)
            MRSS_HOLD: begin
                if (!any_full) begin
                    state_next = MRSS_DELAY;
                end
            end
            MRSS_DELAY: begin
                dly_next = dly_reg + CNT_W'(1);
                if (any_full) begin
                    state_next = MRSS_HOLD;
                    dly_next   = '0;
                end else if (dly_done) begin
                    state_next = MRSS_RUN;
                end
            end
            MRSS_RUN: begin
                if (any_full) begin
                    state_next = MRSS_HOLD;
                end else if (wdt_pd) begin
                    state_next = MRSS_DELAY;
                end
            end
            default: state_next = MRSS_HOLD;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= MRSS_HOLD;
            dly_reg   <= '0;
        end else begin
            state_reg <= state_next;
            dly_reg   <= dly_next;
        end
    end

    // ------------------------------------------------------------------
    // Reset effects and flags
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_pend_reg          <= 1'b1;
            core_run              <= 1'b0;
            pc_clear              <= 1'b1;
            sp_clear              <= 1'b1;
            port_reset            <= 1'b1;
            port_data_init        <= PORT_RESET_VAL;
            port_dir_init         <= PORT_RESET_VAL;
            timer_stop            <= 1'b1;
            watchdog_timeout_flag <= 1'b0;
            powerdown_flag        <= 1'b0;
        end else begin
            por_pend_reg <= 1'b0;
            core_run     <= (state_next == MRSS_RUN);
            pc_clear     <= any_full || wdt_pd;
            sp_clear     <= any_full || wdt_pd;
            port_reset   <= any_full;
            timer_stop   <= any_full;
            if (por_pend_reg) begin
                watchdog_timeout_flag <= 1'b0;
                powerdown_flag        <= 1'b0;
            end else if (wdt_pd) begin
                watchdog_timeout_flag <= 1'b1;
                powerdown_flag        <= 1'b1;
            end else if (wdt_normal) begin
                watchdog_timeout_flag <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // APB registers and interrupt
    // ------------------------------------------------------------------
    logic [EV_W-1:0] ev_reg;
    logic [EV_W-1:0] ev_en_reg;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic            acc;
    logic            done;
    logic            wr;
    logic            hit;
    logic [31:0]     rd_mux;

    assign acc    = psel && penable && !pready;
    // Writes commit at the completing edge, where the master sees pready high.
    assign done   = psel && penable && pready;
    assign wr     = done && pwrite;
    assign hit    = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_EVENT)
                 || (paddr == OFS_CLEAR) || (paddr == OFS_IRQ_EN);
    assign ev_set = {wdt_normal || wdt_pd, lvr_qual, !reset_pin_b, por_pend_reg};
    assign ev_clr = (wr && paddr == OFS_CLEAR) ? pwdata[EV_W-1:0] : '0;
    assign rd_mux =
        (paddr == OFS_CTRL)   ? {28'h0, low_voltage_threshold, ctrl_lvr_en_reg} :
        (paddr == OFS_STATUS) ? {26'h0, state_reg, watchdog_timeout_flag, powerdown_flag,
                                 core_run, 1'b0} :
        (paddr == OFS_EVENT)  ? {28'h0, ev_reg} :
        (paddr == OFS_IRQ_EN) ? {28'h0, ev_en_reg} : 32'h0;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            prdata                <= 32'h0;
            ctrl_lvr_en_reg       <= 1'b1;
            low_voltage_threshold <= LVT_RESET_VAL;
            ev_reg                <= '0;
            ev_en_reg             <= '0;
            irq                   <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc && !hit;
            prdata  <= (acc && !pwrite) ? rd_mux : 32'h0;
            if (wr && paddr == OFS_CTRL) begin
                ctrl_lvr_en_reg       <= pwdata[0];
                low_voltage_threshold <= pwdata[3:1];
            end
            if (wr && paddr == OFS_IRQ_EN) begin
                ev_en_reg <= pwdata[EV_W-1:0];
            end
            // Set wins over a clear in the same cycle.
            ev_reg <= (ev_reg & ~ev_clr) | ev_set;
            irq    <= |(((ev_reg & ~ev_clr) | ev_set) & ev_en_reg);
        end
    end
endmodule

// ---- tb/mrss_checker.sv ----
/* Assertions on the ports of the reset source sequencer top.
   Assumes one clock and the short delay parameters of the bench. */
module mrss_checker #(
    parameter int RELEASE_CYCLES = 8,
    parameter int LOW_CYCLES     = 10
) (
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       reset_pin_b,
    input wire logic       low_supply,
    input wire logic       lvr_option_en,
    input wire logic       watchdog_timeout,
    input wire logic       powerdown,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       core_run,
    input wire logic       pc_clear,
    input wire logic       sp_clear,
    input wire logic       port_reset,
    input wire logic [7:0] port_data_init,
    input wire logic [7:0] port_dir_init,
    input wire logic       timer_stop,
    input wire logic       watchdog_timeout_flag,
    input wire logic       powerdown_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    int quiet_cnt;
    int low_cnt;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_cnt <= 0;
            low_cnt   <= 0;
        end else begin
            quiet_cnt <= reset_pin_b ? quiet_cnt + 1 : 0;
            low_cnt   <= (low_supply && lvr_option_en) ? low_cnt + 1 : 0;
        end
    end
    // ----
    // Assertions
    // ----
    sequence apb_take;
        psel && penable && !pready;
    endsequence
    pin_reset_a: assert property (!reset_pin_b |=> pc_clear && port_reset && timer_stop)
        else $error("pin low did not reset");
    run_blocked_a: assert property (!reset_pin_b |=> !core_run)
        else $error("core ran with pin low");
    start_delay_a: assert property ($rose(core_run) |-> quiet_cnt >= RELEASE_CYCLES)
        else $error("start-up delay too short");
    lvr_short_a: assert property (core_run && reset_pin_b && !watchdog_timeout
        && low_cnt < LOW_CYCLES - 2 |=> core_run) else $error("short low supply reset");
    lvr_long_a: assert property (low_cnt == LOW_CYCLES + 4 |-> port_reset && !core_run)
        else $error("long low supply ignored");
    wdt_normal_a: assert property (watchdog_timeout && !powerdown
        |=> watchdog_timeout_flag && port_reset && !core_run) else $error("wdt reset wrong");
    wdt_sleep_a: assert property (watchdog_timeout && powerdown && core_run && reset_pin_b
        |=> pc_clear && sp_clear && powerdown_flag && !port_reset && !timer_stop)
        else $error("sleep wdt wrong");
    por_state_a: assert property ($rose(rst_b) |-> !watchdog_timeout_flag
        && !powerdown_flag && port_data_init == 8'hff && port_dir_init == 8'hff && pc_clear)
        else $error("power-on state wrong");
    apb_answer_a: assert property (apb_take |=> pready ##1 !pready)
        else $error("apb answer wrong");
endmodule

bind mrss_top mrss_checker #(.RELEASE_CYCLES(RELEASE_CYCLES), .LOW_CYCLES(LOW_CYCLES)) chk_u (
    .sys_clk, .rst_b, .reset_pin_b, .low_supply, .lvr_option_en, .watchdog_timeout,
    .powerdown, .psel, .penable, .pready, .core_run, .pc_clear, .sp_clear, .port_reset,
    .port_data_init, .port_dir_init, .timer_stop, .watchdog_timeout_flag, .powerdown_flag);

// ---- tb/mrss_switch.sv ----
/* External reset switch model on the active-low reset pin.
   Assumes the pin idles high through its pull-up. */
module mrss_switch (
    input  wire logic sys_clk,
    output logic      reset_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reset_pin_b = 1'b1;
    task automatic press(input int n);
        @(posedge sys_clk) reset_pin_b <= 1'b0;
        repeat (n) @(posedge sys_clk);
        reset_pin_b <= 1'b1;
    endtask
endmodule

// ---- tb/testbench.sv ----
/* Self-checking bench for the reset source sequencer.
   Assumes short delay parameters and the switch model on the pin. */
module testbench;
    import mrss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 8;
    localparam int LC = 10;
    logic        sys_clk = 0, rst_b = 0, low_supply = 0, lvr_option_en = 1;
    logic        watchdog_timeout = 0, powerdown = 0, psel = 0, penable = 0, pwrite = 0;
    logic        reset_pin_b, pready, pslverr, serr, core_run, pc_clear, sp_clear, irq;
    logic        port_reset, timer_stop, watchdog_timeout_flag, powerdown_flag;
    logic [7:0]  paddr = 8'h00, port_data_init, port_dir_init;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [2:0]  low_voltage_threshold;
    int          bad_count = 0, n_tests = 0, cyc = 0, c;
    mrss_top #(.RELEASE_CYCLES(RC), .LOW_CYCLES(LC)) dut_u (
        .sys_clk, .rst_b, .reset_pin_b, .low_supply, .lvr_option_en, .watchdog_timeout,
        .powerdown, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .core_run, .pc_clear, .sp_clear, .port_reset, .port_data_init, .port_dir_init,
        .timer_stop, .watchdog_timeout_flag, .powerdown_flag, .low_voltage_threshold, .irq);
    mrss_switch sw_u (.sys_clk, .reset_pin_b);
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    task automatic waitrun();
        c = 0;
        while (core_run !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            c++;
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        chk("ports", {port_data_init, port_dir_init, pc_clear}, 17'h1ffff);
        waitrun();
        chk("pc", {core_run, pc_clear}, 2'b10);
        rd("status", OFS_STATUS, 32'h32);
        rd("ctrl", OFS_CTRL, 32'h1);
        rd("event", OFS_EVENT, 32'h1);
        rd("unmapped", 8'h40, 32'h0);
        chk("slverr", serr, 1'b1);
        apb(1'b1, OFS_IRQ_EN, 32'h1);
        @(posedge sys_clk);
        #1;
        chk("irq up", irq, 1'b1);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        @(posedge sys_clk);
        #1;
        chk("irq masked", irq, 1'b0);
        apb(1'b1, OFS_IRQ_EN, 32'h2);
        apb(1'b1, OFS_CLEAR, 32'hf);
        rd("cleared", OFS_EVENT, 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, OFS_CTRL, 32'({i[2:0], 1'b1}));
            #1;
            chk("threshold", low_voltage_threshold, i[2:0]);
        end
        $display("test registers done");
        sw_u.press(6);
        #1;
        chk("pin", {core_run, pc_clear, port_reset, timer_stop}, 4'h7);
        waitrun();
        chk("delay", c >= RC && c <= RC + 3, 1'b1);
        chk("pin irq", irq, 1'b1);
        rd("pin event", OFS_EVENT, 32'h2);
        $display("test pin done");
        @(posedge sys_clk) low_supply <= 1'b1;
        repeat (LC - 3) @(posedge sys_clk);
        low_supply    <= 1'b0;
        lvr_option_en <= 1'b0;
        @(posedge sys_clk) low_supply <= 1'b1;
        repeat (LC + 6) @(posedge sys_clk);
        low_supply    <= 1'b0;
        lvr_option_en <= 1'b1;
        #1;
        chk("lvr ignored", core_run, 1'b1);
        @(posedge sys_clk) low_supply <= 1'b1;
        repeat (LC + 6) @(posedge sys_clk);
        low_supply <= 1'b0;
        #1;
        chk("lvr", {core_run, port_reset, watchdog_timeout_flag}, 3'b010);
        waitrun();
        rd("lvr event", OFS_EVENT, 32'h6);
        $display("test low supply done");
        @(posedge sys_clk) watchdog_timeout <= 1'b1;
        @(posedge sys_clk) watchdog_timeout <= 1'b0;
        #1;
        chk("wdt", {watchdog_timeout_flag, powerdown_flag, port_reset, timer_stop}, 4'hb);
        waitrun();
        rd("wdt event", OFS_EVENT, 32'he);
        @(posedge sys_clk);
        powerdown        <= 1'b1;
        watchdog_timeout <= 1'b1;
        @(posedge sys_clk) watchdog_timeout <= 1'b0;
        #1;
        chk("sleep", {pc_clear, sp_clear, port_reset, timer_stop}, 4'hc);
        chk("flags", {watchdog_timeout_flag, powerdown_flag}, 2'b11);
        @(posedge sys_clk) powerdown <= 1'b0;
        waitrun();
        $display("test watchdog done");
        @(posedge sys_clk) rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        waitrun();
        chk("por", {watchdog_timeout_flag, powerdown_flag, port_dir_init}, 10'h0ff);
        rd("por event", OFS_EVENT, 32'h1);
        $display("test second power-on done");
        results();
    end
endmodule
